// ===== verilog/scp_pkg.sv
// constants and types for the stepper configuration-mode word block
// assumes a host that writes ten output words and reads ten input words
package scp_pkg;
    // word indices of the ten-word images
    localparam logic [3:0] N_WORDS = 4'hA;
    localparam logic [3:0] W_CFG0 = 4'h0;
    localparam logic [3:0] W_CFG1 = 4'h1;
    localparam logic [3:0] W_SPEED_HI = 4'h2;
    localparam logic [3:0] W_SPEED_LO = 4'h3;
    localparam logic [3:0] W_STEPS = 4'h4;
    localparam logic [3:0] W_ZERO = 4'h5;
    localparam logic [3:0] W_COUNTS = 4'h6;
    localparam logic [3:0] W_STANDBY = 4'h7;
    localparam logic [3:0] W_DRIVE = 4'h8;
    localparam logic [3:0] W_GAIN = 4'h9;
    localparam logic [3:0] W_LAST = 4'h9;
    // first configuration word fields
    localparam int B0_MODE = 15;
    localparam int B0_STALL = 13;
    localparam int B0_RSVD_HI = 12;
    localparam int B0_USE_ENC = 10;
    localparam int B0_RSVD_LO = 9;
    localparam int FN_W = 3;
    // second configuration word fields
    localparam int B1_ROLE = 14;
    localparam int B1_LOSS_FORCE = 13;
    localparam int B1_LOSS_VALUE = 12;
    localparam int B1_READBACK = 11;
    localparam int B1_SAVE = 10;
    localparam int B1_REPORT_32 = 9;
    localparam int B1_CMD_32 = 8;
    localparam int B1_MSW_FIRST = 7;
    localparam int B1_RSVD_TOP = 6;
    localparam int B1_RSVD_BOT = 3;
    // command-mode bit that drives output 1 as a general output
    localparam logic [3:0] CMD_OUT_WORD = 4'h1;
    localparam int CMD_OUT_BIT = 0;
    // input function codes
    localparam logic [2:0] FN_GENERAL = 3'h0;
    localparam logic [2:0] FN_HOME = 3'h6;
    localparam logic [2:0] FN_QUAD = 3'h7;
    // values
    localparam logic [15:0] SPEED_LO_MAX = 16'h03E7;
    localparam logic [15:0] CFG_ERR_STATUS = 16'h6408;
    localparam logic [15:0] STATUS_OK = 16'h0000;
    localparam logic [15:0] SAVE_OK_CODE = 16'hAAAA;
    localparam logic [15:0] SAVE_FAIL_CODE = 16'hEEEE;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    typedef enum logic [1:0] {ST_RUN = 2'b00, ST_SAVE = 2'b01, ST_DONE = 2'b11} scp_state_type;
    typedef enum logic [1:0] {LED_SOLID = 2'b00, LED_GREEN = 2'b01, LED_RED = 2'b10} scp_led_type;

    // one host write, or the end of a network output frame
    typedef struct packed {
        logic valid;
        logic frame_end;
        logic [3:0] index;
        logic [15:0] data;
    } scp_wr_type;

    // data format selections for command mode
    typedef struct packed {
        logic report_32;
        logic cmd_32;
        logic msw_first;
    } scp_fmt_type;
endpackage

// ===== verilog/scp_config_words.sv
// configuration-mode word handling: output image, validation, echo, save, output 1
// assumes host writes and flash answers are on clk_sys; pins arrive asynchronously
`timescale 1ns/1ps
module scp_config_words
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input scp_pkg::scp_wr_type host_wr,
    input wire logic [3:0] rd_index,
    input wire logic link_up_pin,
    input wire logic [2:0] in_pins,
    input wire logic fault,
    input wire logic move_done,
    input wire logic flash_done,
    input wire logic flash_ok,
    output logic [15:0] rd_data,
    output logic flash_req,
    output logic out_a,
    output scp_pkg::scp_led_type led,
    output scp_pkg::scp_fmt_type fmt,
    output logic [2:0] in_active,
    output logic [15:0] standby_current,
    output logic cfg_mode
);
    import scp_pkg::*;

    logic [15:0] out_img [N_WORDS];
    logic [15:0] cfg_act [N_WORDS];
    logic cfg_valid;
    logic word0_status;
    logic mode_prev;
    logic save_prev;
    logic readback;
    scp_state_type state;
    logic [15:0] save_resp;
    logic link_meta;
    logic link_ok;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic standby_pend;
    logic [15:0] standby_next;
    logic mode_now;
    logic [2:0] fn_a;
    logic [2:0] fn_b;
    logic [2:0] fn_c;
    logic quad_pair;
    logic rsvd_bad;
    logic speed_bad;
    logic dup_bad;
    logic quad_bad;
    logic enc_bad;
    logic stall_bad;
    logic cfg_ok;
    logic accept;
    logic save_go;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_meta <= 1'b0;
            link_ok <= 1'b0;
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end
        else
        begin
            link_meta <= link_up_pin;
            link_ok <= link_meta;
            pin_meta <= in_pins;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output image from the host, frozen once the save answer is out
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N_WORDS; i++)
            begin
                out_img[i] <= 16'h0000;
            end
        end
        else if (host_wr.valid && state != ST_DONE && host_wr.index < N_WORDS)
        begin
            out_img[host_wr.index] <= host_wr.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // validity check of the written image
    assign mode_now = out_img[W_CFG0][B0_MODE];
    assign fn_a = out_img[W_CFG0][FN_W-1:0];
    assign fn_b = out_img[W_CFG0][2*FN_W-1:FN_W];
    assign fn_c = out_img[W_CFG0][3*FN_W-1:2*FN_W];
    assign quad_pair = (fn_a == FN_QUAD) && (fn_b == FN_QUAD);
    // second word bit 15 is not looked at
    assign rsvd_bad = out_img[W_CFG0][B0_RSVD_HI] | out_img[W_CFG0][B0_RSVD_LO]
        | (|out_img[W_CFG1][B1_RSVD_TOP:B1_RSVD_BOT]);
    assign speed_bad = out_img[W_SPEED_LO] > SPEED_LO_MAX;
    // quadrature pair on inputs 1 and 2 is the one allowed repeat besides general inputs
    assign dup_bad = (fn_a == fn_b && fn_a != FN_GENERAL && fn_a != FN_QUAD)
        || (fn_a == fn_c && fn_a != FN_GENERAL)
        || (fn_b == fn_c && fn_b != FN_GENERAL);
    assign quad_bad = (fn_c == FN_QUAD) || ((fn_a == FN_QUAD || fn_b == FN_QUAD) && !quad_pair);
    assign enc_bad = out_img[W_CFG0][B0_USE_ENC]
        && (!quad_pair || out_img[W_COUNTS] == ZERO_WORD);
    assign stall_bad = out_img[W_CFG0][B0_STALL] && !out_img[W_CFG0][B0_USE_ENC];
    assign cfg_ok = !(rsvd_bad || speed_bad || dup_bad || quad_bad || enc_bad || stall_bad);
    // writes refused while readback bit is set
    assign accept = host_wr.frame_end && state == ST_RUN && mode_now
        && !out_img[W_CFG1][B1_READBACK] && cfg_ok;
    assign save_go = host_wr.frame_end && state == ST_RUN && mode_now
        && out_img[W_CFG1][B1_SAVE] && !save_prev && cfg_ok;

    ////////////////////////////////////////////////////////////////////////////
    // frame bookkeeping: mode edge, save edge, readback flag
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_prev <= 1'b0;
            save_prev <= 1'b0;
            readback <= 1'b0;
        end
        else if (host_wr.frame_end && state == ST_RUN)
        begin
            mode_prev <= mode_now;
            save_prev <= out_img[W_CFG1][B1_SAVE];
            if (mode_now && !mode_prev && out_img[W_CFG1][B1_READBACK])
            begin
                readback <= 1'b1;
            end
            else if (!out_img[W_CFG1][B1_READBACK] || !mode_now)
            begin
                readback <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accepted configuration and its error state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N_WORDS; i++)
            begin
                cfg_act[i] <= 16'h0000;
            end
            cfg_valid <= 1'b0;
            word0_status <= 1'b1;
        end
        else if (accept)
        begin
            for (int i = 0; i < N_WORDS; i++)
            begin
                cfg_act[i] <= out_img[i];
            end
            cfg_valid <= 1'b1;
            word0_status <= 1'b0;
        end
        else if (host_wr.frame_end && state == ST_RUN && mode_now && !cfg_ok)
        begin
            word0_status <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash save sequence and lock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_RUN;
            flash_req <= 1'b0;
            save_resp <= 16'h0000;
            led <= LED_SOLID;
        end
        else
        begin
            flash_req <= 1'b0;
            case (state)
                ST_RUN:
                begin
                    if (save_go)
                    begin
                        state <= ST_SAVE;
                        flash_req <= 1'b1;
                    end
                end
                ST_SAVE:
                begin
                    if (flash_done)
                    begin
                        state <= ST_DONE;
                        save_resp <= flash_ok ? SAVE_OK_CODE : SAVE_FAIL_CODE;
                        led <= flash_ok ? LED_GREEN : LED_RED;
                    end
                end
                ST_DONE:
                begin
                    state <= ST_DONE;
                end
                default:
                begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input word read-back
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= CFG_ERR_STATUS;
        end
        else if (rd_index == W_CFG0)
        begin
            // bit 13 is stall enable in the echo, config error in the status
            rd_data <= (!cfg_valid || word0_status) ? CFG_ERR_STATUS
                : (mode_now ? cfg_act[W_CFG0] : STATUS_OK);
        end
        else if (rd_index == W_LAST && state == ST_DONE)
        begin
            rd_data <= save_resp;
        end
        else if (rd_index == W_ZERO || rd_index >= N_WORDS)
        begin
            rd_data <= ZERO_WORD;
        end
        else
        begin
            rd_data <= cfg_act[rd_index];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output 1 drive
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_a <= 1'b1;
        end
        else if (!cfg_valid)
        begin
            out_a <= 1'b1;
        end
        else if (!link_ok)
        begin
            if (cfg_act[W_CFG1][B1_LOSS_FORCE])
            begin
                out_a <= cfg_act[W_CFG1][B1_LOSS_VALUE];
            end
        end
        else if (cfg_act[W_CFG1][B1_ROLE])
        begin
            out_a <= out_img[CMD_OUT_WORD][CMD_OUT_BIT] && !mode_now;
        end
        else
        begin
            out_a <= !fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data format selections and mode flag
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fmt <= '0;
            cfg_mode <= 1'b0;
        end
        else
        begin
            fmt.report_32 <= cfg_act[W_CFG1][B1_REPORT_32];
            fmt.cmd_32 <= cfg_act[W_CFG1][B1_CMD_32];
            fmt.msw_first <= cfg_act[W_CFG1][B1_MSW_FIRST]
                && (cfg_act[W_CFG1][B1_REPORT_32] || cfg_act[W_CFG1][B1_CMD_32]);
            cfg_mode <= mode_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // standby current deferred to end of first move
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_pend <= 1'b0;
            standby_next <= 16'h0000;
            standby_current <= 16'h0000;
        end
        else if (accept)
        begin
            standby_pend <= 1'b1;
            standby_next <= out_img[W_STANDBY];
        end
        else if (move_done && standby_pend)
        begin
            standby_pend <= 1'b0;
            standby_current <= standby_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input active levels, encoder channels report polarity
    for (genvar g = 0; g < 3; g++)
    begin : g_in
        logic [2:0] fn;
        logic enc_ch;
        assign fn = cfg_act[W_CFG0][FN_W*g +: FN_W];
        assign enc_ch = fn == FN_QUAD || (g == 2 && fn == FN_HOME && cfg_act[W_CFG0][B0_USE_ENC]);
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                in_active[g] <= 1'b0;
            end
            else if (enc_ch)
            begin
                in_active[g] <= cfg_act[W_CFG1][g];
            end
            else
            begin
                in_active[g] <= cfg_act[W_CFG1][g] ? pin_sync[g] : !pin_sync[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_unconf_out_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!cfg_valid)[*2] |-> out_a) else $error("output 1 off before configuration");
    a_loss_force: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cfg_valid && !link_ok && cfg_act[W_CFG1][B1_LOSS_FORCE])[*2]
        |-> out_a == $past(cfg_act[W_CFG1][B1_LOSS_VALUE])) else $error("forced value wrong");
    a_loss_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cfg_valid && !link_ok && !cfg_act[W_CFG1][B1_LOSS_FORCE])[*2]
        |-> $stable(out_a)) else $error("output 1 moved on link loss");
    a_readback_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        host_wr.frame_end && out_img[W_CFG1][B1_READBACK]
        |=> $stable(cfg_act[W_CFG0]) && $stable(cfg_act[W_STEPS])) else $error("write taken");
    a_save_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flash_req |-> $past(out_img[W_CFG1][B1_SAVE] && !save_prev && cfg_ok))
        else $error("save without valid rising edge");
    a_save_ok_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_SAVE && flash_done && flash_ok
        |=> save_resp == SAVE_OK_CODE && led == LED_GREEN) else $error("bad success answer");
    a_save_fail_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_SAVE && flash_done && !flash_ok
        |=> save_resp == SAVE_FAIL_CODE && led == LED_RED) else $error("bad failure answer");
    a_locked_after: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_DONE |=> state == ST_DONE && !flash_req && $stable(cfg_act[W_CFG0])
        && $stable(out_img[W_CFG1])) else $error("activity after save answer");
    a_endian_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fmt.msw_first |-> fmt.report_32 || fmt.cmd_32) else $error("order without 32-bit");
    a_invalid_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        host_wr.frame_end && !cfg_ok |=> $stable(cfg_act[W_CFG0]) && $stable(cfg_act[W_CFG1]))
        else $error("invalid configuration taken");
    a_word5_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_index == W_ZERO |=> rd_data == ZERO_WORD) else $error("word 5 not zero");
    a_cfg_err_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg_valid && rd_index == W_CFG0 |=> rd_data == CFG_ERR_STATUS)
        else $error("word 0 not config error");
    c_save_ok: cover property (@(posedge clk_sys) disable iff (!rst_n)
        flash_req ##[1:20] (flash_done && flash_ok));
    c_save_fail: cover property (@(posedge clk_sys) disable iff (!rst_n)
        flash_req ##[1:20] (flash_done && !flash_ok));
    c_readback: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(readback));
    c_loss_force: cover property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_valid && !link_ok && cfg_act[W_CFG1][B1_LOSS_FORCE]);
endmodule

// ===== verif/scp_flash_model.sv
// flash memory model answering save requests from the configuration block
// assumes flash_req is a one-cycle pulse on clk_sys; ok_sel chosen by the bench
`timescale 1ns/1ps
module scp_flash_model
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flash_req,
    input wire logic ok_sel,
    output logic flash_done,
    output logic flash_ok
);
    logic [3:0] count;

    ////////////////////////////////////////////////////////////////////////////
    // answer six cycles after a request; ok toggles outside the done pulse
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 4'h0;
            flash_done <= 1'b0;
            flash_ok <= 1'b0;
        end
        else
        begin
            flash_done <= (count == 4'h1);
            flash_ok <= (count == 4'h1) ? ok_sel : ~flash_ok;
            if (flash_req)
                count <= 4'h6;
            else if (count != 4'h0)
                count <= count - 4'h1;
        end
    end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the configuration-mode word block
// assumes the flash model on the far side and host frames driven here
`timescale 1ns/1ps
module tb_top;
    import scp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    scp_wr_type host_wr = '0;
    logic [3:0] rd_index = 4'h0;
    logic link_up_pin = 1'b1;
    logic [2:0] in_pins = 3'h0;
    logic fault = 1'b0;
    logic move_done = 1'b0;
    logic ok_sel = 1'b1;
    logic flash_done, flash_ok, flash_req, out_a, cfg_mode;
    logic [15:0] rd_data, standby_current;
    scp_led_type led;
    scp_fmt_type fmt;
    logic [2:0] in_active;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] img [10];
    logic [3:0] bad_i [7] = '{4'h3, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [15:0] bad_v [7] = '{16'h03E8, 16'h8211, 16'h028D, 16'h8009, 16'h8411, 16'h843F,
        16'hA011};

    ////////////////////////////////////////////////////////////////////////////
    scp_config_words u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_wr(host_wr),
        .rd_index(rd_index), .link_up_pin(link_up_pin), .in_pins(in_pins), .fault(fault),
        .move_done(move_done), .flash_done(flash_done), .flash_ok(flash_ok),
        .rd_data(rd_data), .flash_req(flash_req), .out_a(out_a), .led(led), .fmt(fmt),
        .in_active(in_active), .standby_current(standby_current), .cfg_mode(cfg_mode));
    scp_flash_model u_flash (.clk_sys(clk_sys), .rst_n(rst_n), .flash_req(flash_req),
        .ok_sel(ok_sel), .flash_done(flash_done), .flash_ok(flash_ok));

    // clock and hang guard
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task rd(input logic [3:0] idx, input logic [15:0] exp);
        rd_index = idx;
        tick(1);
        chk(rd_data, exp);
    endtask

    // whole ten-word frame, frame end, one settle cycle
    task frame();
        for (int i = 0; i < 10; i++)
        begin
            host_wr = '{1'b1, 1'b0, 4'(i), img[i]};
            tick(1);
        end
        host_wr = '{1'b0, 1'b1, 4'h0, 16'h0000};
        tick(1);
        host_wr = '0;
        tick(1);
    endtask

    task set_good();
        img = '{16'h8011, 16'h0285, 16'h0001, 16'h03E7, 16'h00C8, 16'h1234, 16'h0000,
            16'h0032, 16'h0014, 16'h0005};
    endtask

    task do_reset();
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        do_reset();
        chk(rd_data, CFG_ERR_STATUS);
        chk({15'h0, out_a}, 16'h0001);
        set_good();
        frame();
        for (int i = 1; i < 10; i++)
            rd(4'(i), (i == 5) ? ZERO_WORD : img[i]);
        rd(W_CFG0, 16'h8011);
        chk({13'h0, fmt}, 16'h0005);
        chk({15'h0, cfg_mode}, 16'h0001);
        chk(standby_current, 16'h0000);
        move_done = 1'b1;
        tick(1);
        move_done = 1'b0;
        tick(1);
        chk(standby_current, 16'h0032);
        in_pins = 3'b001;
        tick(4);
        chk({13'h0, in_active}, 16'h0003);
        chk({15'h0, out_a}, 16'h0001);
        fault = 1'b1;
        tick(2);
        chk({15'h0, out_a}, 16'h0000);
        fault = 1'b0;
        // output 1 as general output, then command mode drives it
        set_good();
        img[1] = 16'h4285;
        frame();
        chk({15'h0, out_a}, 16'h0000);
        img[0] = 16'h0000;
        img[1] = 16'h0001;
        frame();
        chk({15'h0, out_a}, 16'h0001);
        chk({15'h0, cfg_mode}, 16'h0000);
        rd(W_CFG0, STATUS_OK);
        for (int k = 0; k < 7; k++)
        begin
            set_good();
            img[bad_i[k]] = bad_v[k];
            frame();
            rd(W_CFG0, CFG_ERR_STATUS);
        end
        set_good();
        img[1] = 16'h8080;
        frame();
        chk({13'h0, fmt}, 16'h0000);
        img[0] = 16'hA43F;
        img[1] = 16'h2285;
        img[6] = 16'h0190;
        frame();
        rd(W_CFG0, 16'hA43F);
        in_pins = 3'b110;
        link_up_pin = 1'b0;
        tick(4);
        chk({13'h0, in_active}, 16'h0005);
        chk({15'h0, out_a}, 16'h0000);
        // forcing off while the link stays down: output 1 keeps its value
        img[1] = 16'h0285;
        frame();
        chk({15'h0, out_a}, 16'h0000);
        link_up_pin = 1'b1;
        img[1] = 16'h2A85;
        img[4] = 16'h0099;
        frame();
        rd(W_STEPS, 16'h00C8);
        for (int s = 0; s < 2; s++)
        begin
            ok_sel = 1'(s);
            set_good();
            frame();
            img[1] = 16'h0685;
            img[3] = 16'h03E8;
            frame();
            tick(10);
            chk({14'h0, led}, {14'h0, LED_SOLID});
            img[3] = 16'h03E7;
            frame();
            tick(10);
            chk({14'h0, led}, {14'h0, LED_SOLID});
            img[1] = 16'h0285;
            frame();
            img[1] = 16'h0685;
            frame();
            for (int t = 0; t < 50 && led === LED_SOLID; t++)
                tick(1);
            chk({14'h0, led}, {14'h0, (s == 1) ? LED_GREEN : LED_RED});
            rd(W_LAST, (s == 1) ? SAVE_OK_CODE : SAVE_FAIL_CODE);
            img[1] = 16'h0285;
            img[4] = 16'h0077;
            frame();
            rd(W_STEPS, 16'h00C8);
            do_reset();
        end
        results();
    end
endmodule
